// ==== hw/eee_global_ctrl.sv ====
// eee global register bank: idle-queue timers, next-page enables, wakeup errors
// assumes host port, queue status and wakeup measurement all run on core_clk
`timescale 1ns/1ns
module eee_global_ctrl
	import eee_pkg::*;
#(
	parameter int TICK_CYCLES = EEE_TICK_CYCLES
) (
	input  wire logic                 core_clk,
	input  wire logic                 reset_n,
	input  wire logic [7:0]           reg_addr,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	input  wire logic [7:0]           reg_wdata,
	output logic      [7:0]           reg_rdata,
	input  wire logic                 eee_100_en,
	input  wire logic [EEE_NPORT-1:0] transmit_queue_empty,
	input  wire logic [EEE_NPORT-1:0] input_traffic,
	input  wire logic                 wake_done,
	input  wire logic [15:0]          wake_time,
	output logic      [EEE_NPORT-1:0] lpi_request,
	output logic      [EEE_NPORT-1:0] next_page_en,
	output logic      [15:0]          wakeup_error_count
);

	// ---------------------------------------------------------------
	// elaboration checks
	// ---------------------------------------------------------------
	if (TICK_CYCLES < 1 || TICK_CYCLES > 65536) begin : g_bad_tick
		$error("tick count must lie in 1..65536");
	end

	localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

	eee_state_t st;
	eee_state_t next_st;
	logic       tick;
	logic       glob_sel;
	logic       data_wr;

	// ---------------------------------------------------------------
	// byte read of the global table
	// ---------------------------------------------------------------
	function automatic logic [7:0] eee_read_byte(
		input logic [7:0]  ofs,
		input logic        term_en,
		input logic [15:0] wait_time,
		input logic [3:0]  np_en
	);
		logic [15:0] word;
		word = 16'h0000;
		case ({ofs[7:1], 1'b0})
			EEE_OFS_G0:     word = EEE_G0_FIXED | (16'(term_en) << EEE_TERM_BIT);
			EEE_OFS_WAIT:   word = wait_time;
			EEE_OFS_NP:     word = EEE_NP_FIXED | {12'h000, np_en};
			EEE_OFS_MINIDL: word = EEE_MINIDL_VAL;
			EEE_OFS_THRESH: word = EEE_THRESH;
			EEE_OFS_DIAG:   word = EEE_DIAG_VAL;
			default:        word = 16'h0000;
		endcase
		// even offset gives the high byte, odd the low byte
		return ofs[0] ? word[7:0] : word[15:8];
	endfunction : eee_read_byte

	// ---------------------------------------------------------------
	// decode and tick
	// ---------------------------------------------------------------
	// only table 001, port 0 reaches this bank; other selections are ignored
	assign glob_sel = (st.ctrl_sel[7:EEE_TABLE_LSB] == EEE_TABLE_EEE)
		&& (st.ctrl_sel[EEE_PORT_MSB:0] == EEE_PORT_GLOB);
	assign data_wr  = reg_wr && (reg_addr == EEE_ADDR_DATA) && glob_sel;
	assign tick     = (st.prescale == TICK_LAST);

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		next_st = st;

		// host selector and offset registers
		if (reg_wr && reg_addr == EEE_ADDR_CTRL) begin
			next_st.ctrl_sel = reg_wdata;
		end
		if (reg_wr && reg_addr == EEE_ADDR_OFS) begin
			next_st.ofs = reg_wdata;
		end

		// byte writes through the data register; fixed fields drop the write
		if (data_wr) begin
			case (st.ofs)
				EEE_OFS_G0 + 8'h01:   next_st.term_en = reg_wdata[EEE_TERM_BIT];
				EEE_OFS_WAIT:         next_st.wait_time[15:8] = reg_wdata;
				EEE_OFS_WAIT + 8'h01: next_st.wait_time[7:0] = reg_wdata;
				EEE_OFS_NP + 8'h01:   next_st.np_en = reg_wdata[3:0];
				default:              next_st.np_en = st.np_en;
			endcase
		end

		// read data is captured once and held until the next read
		if (reg_rd) begin
			case (reg_addr)
				EEE_ADDR_CTRL: next_st.rdata = st.ctrl_sel;
				EEE_ADDR_OFS:  next_st.rdata = st.ofs;
				EEE_ADDR_DATA: next_st.rdata = glob_sel
					? eee_read_byte(st.ofs, st.term_en, st.wait_time, st.np_en)
					: 8'h00;
				default:       next_st.rdata = 8'h00;
			endcase
		end

		// free-running prescaler, shared by all ports to save counters
		next_st.prescale = tick ? 16'h0000 : 16'(st.prescale + 16'h0001);

		// per-port empty-queue timers and idle requests
		for (int i = 0; i < EEE_NPORT; i++) begin
			if (!eee_100_en || !transmit_queue_empty[i]) begin
				next_st.timer[i] = 16'h0000;
				next_st.lpi[i]   = 1'b0;
			end else if (st.term_en && input_traffic[i]) begin
				next_st.timer[i] = 16'h0000;
				next_st.lpi[i]   = 1'b0;
			end else begin
				// saturate so a long idle never wraps back to zero
				if (tick && st.timer[i] != 16'hFFFF) begin
					next_st.timer[i] = 16'(st.timer[i] + 16'h0001);
				end
				if (st.timer[i] > st.wait_time) begin
					next_st.lpi[i] = 1'b1;
				end
			end
		end

		// wakeup error counter, saturating
		if (wake_done && wake_time > EEE_THRESH && st.werr != 16'hFFFF) begin
			next_st.werr = 16'(st.werr + 16'h0001);
		end

		if (!reset_n) begin
			next_st           = '0;
			next_st.wait_time = EEE_WAIT_RST;
			next_st.np_en     = EEE_NP_RST;
		end
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		st <= next_st;
	end

	// outputs come straight from the state flops
	assign reg_rdata          = st.rdata;
	assign lpi_request        = st.lpi;
	assign next_page_en       = st.np_en;
	assign wakeup_error_count = st.werr;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	chk_lpi_exceeds_wait: assert property (
		$rose(lpi_request[0]) |-> $past(st.timer[0] > st.wait_time))
		else $error("idle request rose before wait time exceeded");

	chk_tick_period: assert property (
		tick |=> st.prescale == 16'h0000)
		else $error("prescaler did not restart after tick");

	chk_lpi_needs_eee: assert property (
		!eee_100_en |=> lpi_request == '0)
		else $error("idle request while eee disabled");

	chk_wait_reset_val: assert property (@(posedge core_clk) disable iff (1'b0)
		!reset_n |=> st.wait_time == EEE_WAIT_RST)
		else $error("wait time reset value wrong");

	chk_np_reset_val: assert property (@(posedge core_clk) disable iff (1'b0)
		!reset_n |=> next_page_en == EEE_NP_RST)
		else $error("next-page enables not one after reset");

	chk_np_write: assert property (
		data_wr && st.ofs == EEE_OFS_NP + 8'h01 |=> next_page_en == $past(reg_wdata[3:0]))
		else $error("next-page enable write lost");

	chk_thresh_read: assert property (
		reg_rd && reg_addr == EEE_ADDR_DATA && glob_sel && st.ofs == EEE_OFS_THRESH
		|=> reg_rdata == EEE_THRESH[15:8])
		else $error("threshold high byte wrong");

	chk_werr_incr: assert property (
		wake_done && wake_time > EEE_THRESH && wakeup_error_count != 16'hFFFF
		|=> wakeup_error_count == $past(wakeup_error_count) + 16'h0001)
		else $error("wakeup error not counted");

	chk_wait_hi_write: assert property (
		data_wr && st.ofs == EEE_OFS_WAIT |=> st.wait_time[15:8] == $past(reg_wdata))
		else $error("wait high byte write lost");

	chk_term_stop: assert property (
		st.term_en && input_traffic[0] |=> !lpi_request[0] && st.timer[0] == 16'h0000)
		else $error("input traffic did not withdraw request");

	chk_busy_restart: assert property (
		!transmit_queue_empty[0] |=> !lpi_request[0] && st.timer[0] == 16'h0000)
		else $error("busy queue did not restart timer");

	cov_lpi_rise: cover property ($rose(lpi_request[0]));
	cov_werr_incr: cover property (wake_done && wake_time > EEE_THRESH);
	cov_term_stop: cover property (st.term_en && (lpi_request & input_traffic) != '0);

endmodule : eee_global_ctrl

// ==== hw/eee_pkg.sv ====
// constants, register layout and state type of the eee global register bank
// assumes a 10 MHz core clock and a byte-wide host register port on the same clock
//
// What this block does
// - raise a port's idle request once its transmit queue stays empty beyond the wait
// - each count of the 16-bit wait field is one 1.3 ms unit
// - wait applies only with 100 Mbit eee enabled; one setting serves all ports
// - wait field is read/write, resets to 0x10, spans 1.3 ms to 85 s
// - per-port next-page enable bits 0..3 allow or skip next-page exchange
// - next-page enable bits reset to one and stay writable
// - wakeup threshold reads as fixed 0x0201
// - each 16-bit register: even offset holds bits 15..8, odd offset bits 7..0
// - host writes byte offset, then moves the byte through data register 0xA0
// - with traffic-stop enabled, input traffic withdraws a pending idle request
package eee_pkg;

	// ---------------------------------------------------------------
	// host port addresses and selector layout
	// ---------------------------------------------------------------
	localparam logic [7:0] EEE_ADDR_CTRL  = 8'h6E;
	localparam logic [7:0] EEE_ADDR_OFS   = 8'h6F;
	localparam logic [7:0] EEE_ADDR_DATA  = 8'hA0;
	localparam logic [2:0] EEE_TABLE_EEE  = 3'h1;
	localparam logic [3:0] EEE_PORT_GLOB  = 4'h0;
	localparam int         EEE_TABLE_LSB  = 5;
	localparam int         EEE_PORT_MSB   = 3;

	// ---------------------------------------------------------------
	// indirect byte offsets (even = high byte, odd = low byte)
	// ---------------------------------------------------------------
	localparam logic [7:0] EEE_OFS_G0     = 8'h30;
	localparam logic [7:0] EEE_OFS_WAIT   = 8'h32;
	localparam logic [7:0] EEE_OFS_NP     = 8'h34;
	localparam logic [7:0] EEE_OFS_MINIDL = 8'h36;
	localparam logic [7:0] EEE_OFS_THRESH = 8'h38;
	localparam logic [7:0] EEE_OFS_DIAG   = 8'h3A;

	// ---------------------------------------------------------------
	// reset and fixed values
	// ---------------------------------------------------------------
	localparam logic [15:0] EEE_WAIT_RST   = 16'h0010;
	localparam logic [3:0]  EEE_NP_RST     = 4'hF;
	localparam logic [15:0] EEE_THRESH     = 16'h0201;
	localparam logic [15:0] EEE_NP_FIXED   = 16'h6800;
	localparam logic [15:0] EEE_G0_FIXED   = 16'h4010;
	localparam logic [15:0] EEE_MINIDL_VAL = 16'h0000;
	localparam logic [15:0] EEE_DIAG_VAL   = 16'h0001;
	localparam int          EEE_TERM_BIT   = 7;
	localparam int          EEE_NPORT      = 4;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int EEE_CLK_NS      = 100;
	localparam int EEE_TICK_NS     = 1300000;
	localparam int EEE_TICK_CYCLES = (EEE_TICK_NS + EEE_CLK_NS - 1) / EEE_CLK_NS;

	// ---------------------------------------------------------------
	// whole state of the bank
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [7:0]                  ctrl_sel;
		logic [7:0]                  ofs;
		logic [7:0]                  rdata;
		logic                        term_en;
		logic [15:0]                 wait_time;
		logic [EEE_NPORT-1:0]        np_en;
		logic [15:0]                 prescale;
		logic [EEE_NPORT-1:0][15:0]  timer;
		logic [EEE_NPORT-1:0]        lpi;
		logic [15:0]                 werr;
	} eee_state_t;

endpackage : eee_pkg

// ==== verif/eee_global_ctrl_tb.sv ====
// self-checking bench for the eee global register bank, with a behavioural model
// assumes hw/eee_pkg.sv is compiled first; the bench drives every input on falling edges
`timescale 1ns/1ns
module eee_global_ctrl_tb;
	import eee_pkg::*;
	localparam int TK = 4; // short idle tick keeps the run brief
	logic        core_clk;
	logic        reset_n;
	logic [7:0]  reg_addr;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_wdata;
	logic [7:0]  reg_rdata;
	logic        eee_100_en;
	logic [3:0]  transmit_queue_empty;
	logic [3:0]  input_traffic;
	logic        wake_done;
	logic [15:0] wake_time;
	logic [3:0]  lpi_request;
	logic [3:0]  next_page_en;
	logic [15:0] wakeup_error_count;
	int          n_mismatch;
	int          checks;
	int          seed;
	int          i;
	int          werr;
	logic [7:0]  b;
	logic [15:0] wait_m;
	logic [3:0]  np_m;
	logic        term_m;
	logic        sel_ok;

	eee_global_ctrl #(.TICK_CYCLES(TK)) DUT (.core_clk(core_clk), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .eee_100_en(eee_100_en),
		.transmit_queue_empty(transmit_queue_empty), .input_traffic(input_traffic),
		.wake_done(wake_done), .wake_time(wake_time), .lpi_request(lpi_request),
		.next_page_en(next_page_en), .wakeup_error_count(wakeup_error_count));

	// ----------------------------------------
	// clock and watchdog
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	initial begin
		#2000000;
		n_mismatch++;
		give_verdict();
	end

	// ----------------------------------------
	// comparisons, host cycles and model
	// ----------------------------------------
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk_byte
	task automatic chk_port(input logic [15:0] got, input logic [15:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk_port
	// strobe held for exactly one rising edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
		@(negedge core_clk);
		d = reg_rdata;
	endtask : rd
	// expected byte: even offset high half, odd offset low half
	function automatic logic [7:0] mdl(input logic [7:0] o);
		logic [15:0] w;
		case (o & 8'hFE)
			8'h30: w = {8'h40, term_m, 7'h10};
			8'h32: w = wait_m;
			8'h34: w = {12'h680, np_m};
			8'h38: w = 16'h0201;
			8'h3A: w = 16'h0001;
			default: w = 16'h0000;
		endcase
		return sel_ok ? (o[0] ? w[7:0] : w[15:8]) : 8'h00;
	endfunction : mdl
	task automatic rchk(input logic [7:0] o);
		wr(8'h6F, o);
		rd(8'hA0, b);
		chk_byte(b, mdl(o), "register byte");
	endtask : rchk
	// only writable fields reach the model; read-only ones must ignore the write
	task automatic wreg(input logic [7:0] o, input logic [7:0] d);
		wr(8'h6F, o);
		wr(8'hA0, d);
		if (sel_ok && o == 8'h31) term_m = d[7];
		if (sel_ok && o == 8'h32) wait_m[15:8] = d;
		if (sel_ok && o == 8'h33) wait_m[7:0] = d;
		if (sel_ok && o == 8'h35) np_m = d[3:0];
	endtask : wreg
	// request must appear after wait+1 ticks, tick phase free
	task automatic wait_lpi(input logic [3:0] m);
		int n;
		n = 0;
		while (lpi_request !== m && n < 200) begin
			@(negedge core_clk);
			n++;
		end
		chk_port(lpi_request, m, "idle request");
		chk_port(16'(n > wait_m * TK && n <= (wait_m + 1) * TK + 2), 16'h0001, "delay");
	endtask : wait_lpi
	task automatic give_verdict();
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{reset_n, reg_wr, reg_rd, eee_100_en, wake_done, term_m, sel_ok} = 7'h00;
		{reg_addr, reg_wdata, transmit_queue_empty, input_traffic} = 24'h000000;
		wake_time = 16'h0000;
		n_mismatch = 0;
		checks = 0;
		werr = 0;
		// model starts from the reset values of the bank
		wait_m = 16'h0010;
		np_m = 4'hF;
		seed = 16273;
		repeat (4) @(negedge core_clk);
		reset_n = 1'b1;
		chk_port({next_page_en, lpi_request, wakeup_error_count[7:0]}, 16'hF000, "reset");
		wr(8'h6E, 8'h20);
		sel_ok = 1'b1;
		for (i = 8'h30; i < 8'h3C; i++) rchk(8'(i));
		rchk(8'h50);
		// random bytes everywhere; read-only places must not move
		for (i = 8'h30; i < 8'h3C; i++) wreg(8'(i), 8'($random(seed)));
		for (i = 8'h30; i < 8'h3C; i++) rchk(8'(i));
		chk_port(next_page_en, np_m, "next page");
		// wrong port select hides the bank and drops writes
		wr(8'h6E, 8'h21);
		sel_ok = 1'b0;
		wreg(8'h33, 8'h55);
		rchk(8'h32);
		wr(8'h6E, 8'h20);
		sel_ok = 1'b1;
		rchk(8'h33);
		rd(8'h6E, b);
		chk_byte(b, 8'h20, "select readback");
		wreg(8'h31, 8'h00);
		wreg(8'h32, 8'h00);
		wreg(8'h33, 8'h02);
		// idle timers on ports 0 and 2, shared wait
		@(negedge core_clk);
		eee_100_en = 1'b1;
		transmit_queue_empty = 4'b0101;
		wait_lpi(4'b0101);
		transmit_queue_empty = 4'b0100;
		input_traffic = 4'b0100;
		repeat (3) @(negedge core_clk);
		chk_port(lpi_request, 16'h0004, "queue refill");
		input_traffic = 4'b0000;
		wreg(8'h31, 8'h80);
		// port 0 idle again so traffic, not a busy queue, holds its timer
		transmit_queue_empty = 4'b0101;
		input_traffic = 4'b0101;
		repeat (2) @(negedge core_clk);
		chk_port(lpi_request, 16'h0000, "traffic stop");
		input_traffic = 4'b0000;
		transmit_queue_empty = 4'b0100;
		wait_lpi(4'b0100);
		eee_100_en = 1'b0;
		repeat (2) @(negedge core_clk);
		chk_port(lpi_request, 16'h0000, "eee off");
		// wakeup times scattered round the fixed threshold
		for (i = 0; i < 24; i++) begin
			wake_time = 16'h01FD + 16'($random(seed) & 7);
			wake_done = 1'b1;
			if (wake_time > 16'h0201) werr++;
			@(negedge core_clk);
			wake_done = 1'b0;
			@(negedge core_clk);
			chk_port(wakeup_error_count, 16'(werr), "wakeup errors");
		end
		give_verdict();
	end
endmodule : eee_global_ctrl_tb
